//--- rsw_pkg.sv
// Contract
// - Seconds count advances each second while enabled and neither flag is set.
// - Count writes take effect only while the timer is stopped.
// - Match register is writable and readable by software.
// - Count register is readable at any time and loadable only while the timer is stopped.
// - Writing the wake register sets the wake enable and, with the master enable on, starts a 1 kHz countdown.
// - Software reset bit clears all registers and stays until software clears it.
// - Alarm and wake-up flags each have an interrupt enable.
// - Master enable gates everything; wake-up timer never runs without it.
// - Alarm and wake-up each separately enabled as deep power-down wake source.
package rsw_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0] RSW_CTRL_OFS  = 8'h00;
    localparam logic [7:0] RSW_MATCH_OFS = 8'h04;
    localparam logic [7:0] RSW_COUNT_OFS = 8'h08;
    localparam logic [7:0] RSW_WAKE_OFS  = 8'h0c;
    localparam logic [7:0] RSW_STAT_OFS  = 8'h10;
    localparam logic [7:0] RSW_MASK_OFS  = 8'h14;
    localparam logic [7:0] RSW_SUBS_OFS  = 8'h18;

    // ==========================================
    // Control fields
    localparam int RSW_CTRL_SWRST_BIT = 0;
    localparam int RSW_CTRL_ENA_BIT   = 1;
    localparam int RSW_CTRL_WKEN_BIT  = 2;
    localparam int RSW_CTRL_SUBEN_BIT = 3;
    localparam int RSW_CTRL_DPDA_BIT  = 4;
    localparam int RSW_CTRL_DPDW_BIT  = 5;
    localparam int RSW_CTRL_W         = 6;

    // Status / mask fields
    localparam int RSW_ST_ALARM_BIT = 0;
    localparam int RSW_ST_WAKE_BIT  = 1;
    localparam int RSW_ST_W         = 2;

    localparam logic [31:0] RSW_RESET_VAL = 32'h0000_0000;
    localparam int          RSW_WAKE_W    = 16;
    localparam int          RSW_SUBS_W    = 15;

    // ==========================================
    // Timing
    localparam longint RSW_CLK_HZ    = 100_000_000;
    localparam longint RSW_SEC_HZ    = 1;
    localparam longint RSW_MS_HZ     = 1_000;
    localparam longint RSW_SUB_HZ    = 32_768;
    localparam int     RSW_SEC_CYC   = int'(RSW_CLK_HZ / RSW_SEC_HZ);
    localparam int     RSW_MS_CYC    = int'(RSW_CLK_HZ / RSW_MS_HZ);
    localparam int     RSW_SUB_CYC   = int'(RSW_CLK_HZ / RSW_SUB_HZ);

    typedef struct packed {
        logic ena;
        logic wken;
        logic suben;
    } rsw_run_type;

endpackage

//--- rsw_top.sv
`timescale 1ns/10ps
module rsw_top
    import rsw_pkg::*;
#(
    parameter int SEC_CYC = RSW_SEC_CYC,
    parameter int MS_CYC  = RSW_MS_CYC,
    parameter int SUB_CYC = RSW_SUB_CYC
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             dpd_wake
);

    // ==========================================
    // Registers
    logic [RSW_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [31:0]           match_r, match_nxt;
    logic [31:0]           count_r, count_nxt;
    logic [RSW_WAKE_W-1:0] wake_r, wake_nxt;
    logic [RSW_ST_W-1:0]   stat_r, stat_nxt;
    logic [RSW_ST_W-1:0]   mask_r, mask_nxt;
    logic [RSW_SUBS_W-1:0] subs_r, subs_nxt;
    logic [31:0]           prdata_nxt;
    logic                  irq_nxt;
    logic                  dpd_wake_nxt;

    rsw_run_type           run;
    logic                  wr;
    logic                  rd_setup;
    logic                  swrst;
    logic                  wake_wr;
    logic                  sec_tick;
    logic                  ms_tick;
    logic                  sub_tick;
    logic [RSW_ST_W-1:0]   ev;

    // ==========================================
    // Divider storage: seconds, milliseconds, sub-second
    localparam int NDIV = 3;
    logic [31:0]           div_r   [NDIV];
    logic [31:0]           div_nxt [NDIV];
    logic [31:0]           div_end [NDIV];
    logic [NDIV-1:0]       div_run;
    logic [NDIV-1:0]       div_clr;
    logic [NDIV-1:0]       div_tick;

    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign swrst    = ctrl_r[RSW_CTRL_SWRST_BIT];
    assign wake_wr  = wr && (paddr == RSW_WAKE_OFS);

    // Wake-up and sub-second need the master enable
    assign run.ena   = ctrl_r[RSW_CTRL_ENA_BIT] && !swrst;
    assign run.wken  = run.ena && ctrl_r[RSW_CTRL_WKEN_BIT];
    assign run.suben = run.ena && ctrl_r[RSW_CTRL_SUBEN_BIT];

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // ==========================================
    // Rate dividers
    assign div_run[0] = run.ena;
    assign div_run[1] = run.wken;
    assign div_run[2] = run.suben;
    assign div_end[0] = 32'(SEC_CYC - 1);
    assign div_end[1] = 32'(MS_CYC - 1);
    assign div_end[2] = 32'(SUB_CYC - 1);
    // A wake write restarts the millisecond phase
    assign div_clr[0] = 1'b0;
    assign div_clr[1] = wake_wr;
    assign div_clr[2] = 1'b0;

    generate
        for (genvar i = 0; i < NDIV; i++)
        begin : g_div
            assign div_tick[i] = div_run[i] && (div_r[i] == div_end[i]);

            always_comb
            begin
                if (!div_run[i] || div_tick[i] || div_clr[i])
                    div_nxt[i] = 32'h0;
                else
                    div_nxt[i] = div_r[i] + 32'h1;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    div_r[i] <= '0;
                else
                    div_r[i] <= div_nxt[i];
            end
        end
    endgenerate

    assign sec_tick = div_tick[0];
    assign ms_tick  = div_tick[1];
    assign sub_tick = div_tick[2];

    // ==========================================
    // Events
    assign ev[RSW_ST_ALARM_BIT] = run.ena && (count_r == match_r);
    assign ev[RSW_ST_WAKE_BIT]  = ms_tick && (wake_r == RSW_WAKE_W'(1));

    // ==========================================
    // Control register
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        // Write wins over soft reset so software can leave it
        if (wr && (paddr == RSW_CTRL_OFS))
            ctrl_nxt = pwdata[RSW_CTRL_W-1:0];
        else if (swrst)
            ctrl_nxt = RSW_CTRL_W'(1);
        else if (wake_wr)
            ctrl_nxt[RSW_CTRL_WKEN_BIT] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= '0;
        else
            ctrl_r <= ctrl_nxt;
    end

    // ==========================================
    // Match register
    always_comb
    begin
        match_nxt = match_r;
        if (wr && (paddr == RSW_MATCH_OFS))
            match_nxt = pwdata;
        if (swrst)
            match_nxt = RSW_RESET_VAL;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_r <= RSW_RESET_VAL;
        else
            match_r <= match_nxt;
    end

    // ==========================================
    // Seconds count
    always_comb
    begin
        count_nxt = count_r;
        // Held while any flag stands
        if (sec_tick && (stat_r == '0))
            count_nxt = count_r + 32'h1;
        if (wr && (paddr == RSW_COUNT_OFS) && !run.ena)
            count_nxt = pwdata;
        if (swrst)
            count_nxt = RSW_RESET_VAL;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= RSW_RESET_VAL;
        else
            count_r <= count_nxt;
    end

    // ==========================================
    // Wake-up countdown
    always_comb
    begin
        wake_nxt = wake_r;
        // Holds at zero once expired
        if (ms_tick && (wake_r != '0))
            wake_nxt = wake_r - RSW_WAKE_W'(1);
        if (wake_wr)
            wake_nxt = pwdata[RSW_WAKE_W-1:0];
        if (swrst)
            wake_nxt = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_r <= '0;
        else
            wake_r <= wake_nxt;
    end

    // ==========================================
    // Status flags, write one to clear, set wins
    generate
        for (genvar b = 0; b < RSW_ST_W; b++)
        begin : g_stat
            assign stat_nxt[b] = !swrst
                              && (ev[b] || (stat_r[b] && !(wr && (paddr == RSW_STAT_OFS) && pwdata[b])));
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_r <= '0;
        else
            stat_r <= stat_nxt;
    end

    // ==========================================
    // Interrupt mask
    always_comb
    begin
        mask_nxt = mask_r;
        if (wr && (paddr == RSW_MASK_OFS))
            mask_nxt = pwdata[RSW_ST_W-1:0];
        if (swrst)
            mask_nxt = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_r <= '0;
        else
            mask_r <= mask_nxt;
    end

    // ==========================================
    // Sub-second counter
    always_comb
    begin
        subs_nxt = subs_r;
        if (sub_tick)
            subs_nxt = subs_r + RSW_SUBS_W'(1);
        if (swrst)
            subs_nxt = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            subs_r <= '0;
        else
            subs_r <= subs_nxt;
    end

    // ==========================================
    // Read data
    always_comb
    begin
        // Loaded at setup so it stands through the access phase
        prdata_nxt = prdata;
        if (rd_setup)
        begin
            case (paddr)
                RSW_CTRL_OFS:  prdata_nxt = 32'(ctrl_r);
                RSW_MATCH_OFS: prdata_nxt = match_r;
                RSW_COUNT_OFS: prdata_nxt = count_r;
                RSW_WAKE_OFS:  prdata_nxt = 32'(wake_r);
                RSW_STAT_OFS:  prdata_nxt = 32'(stat_r);
                RSW_MASK_OFS:  prdata_nxt = 32'(mask_r);
                RSW_SUBS_OFS:  prdata_nxt = 32'(subs_r);
                default:       prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else
            prdata <= prdata_nxt;
    end

    // ==========================================
    // Interrupt and wake outputs
    always_comb
    begin
        // Taken from next state so they track the flags exactly
        irq_nxt      = |(stat_nxt & mask_nxt);
        dpd_wake_nxt = (stat_nxt[RSW_ST_ALARM_BIT] && ctrl_nxt[RSW_CTRL_DPDA_BIT])
                    || (stat_nxt[RSW_ST_WAKE_BIT] && ctrl_nxt[RSW_CTRL_DPDW_BIT]);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq      <= 1'b0;
            dpd_wake <= 1'b0;
        end
        else
        begin
            irq      <= irq_nxt;
            dpd_wake <= dpd_wake_nxt;
        end
    end

endmodule

//--- rsw_checker.sv
`timescale 1ns/10ps
module rsw_checker import rsw_pkg::*; (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        dpd_wake
);
    // ==========
    // Shadow of written registers
    logic [5:0]  ct_r;
    logic [31:0] mt_r;
    logic [1:0]  mk_r;
    wire         wr = psel && penable && pready && pwrite, rd = psel && !penable && !pwrite;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {ct_r, mt_r, mk_r} <= '0;
        else if (wr && paddr == RSW_CTRL_OFS) ct_r <= pwdata[5:0];
        else if (ct_r[0]) {mt_r, mk_r} <= '0;
        else if (wr && paddr == RSW_MATCH_OFS) mt_r <= pwdata;
        else if (wr && paddr == RSW_MASK_OFS) mk_r <= pwdata[1:0];
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    bus_ready_a: assert property (pready) else $error("no ready");
    no_err_a: assert property (!pslverr) else $error("error response");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    match_back_a: assert property (rd && paddr == RSW_MATCH_OFS && !ct_r[0] |=> prdata == mt_r)
        else $error("match readback");
    soft_rst_a: assert property (ct_r[0] |-> ##2 !irq && !dpd_wake) else $error("output in soft reset");
    mask_off_a: assert property (wr && paddr == RSW_MASK_OFS && pwdata[1:0] == 2'h0 |=> ##1 !irq)
        else $error("irq while masked");
    irq_src_a: assert property (irq |-> (mk_r | $past(mk_r)) != 2'h0) else $error("irq without mask");
    dpd_src_a: assert property (dpd_wake |-> ((ct_r | $past(ct_r)) & 6'h30) != 6'h0) else $error("wake unasked");
    cover property (irq);
    cover property (dpd_wake);
    cover property (wr && paddr == RSW_WAKE_OFS);
endmodule
bind rsw_top rsw_checker chk (.*);

//--- test_rtc_seconds_wakeup_timer.sv
`timescale 1ns/10ps
module test_rtc_seconds_wakeup_timer;
    import rsw_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, dpd_wake;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, m, e;
    logic [31:0] q[$];
    int          fails = 0, num_checks = 0, seed = 60;
    always #5 pclk = ~pclk;
    rsw_top #(.SEC_CYC(20), .MS_CYC(5), .SUB_CYC(3)) dut (.*);
    task automatic wait_for(input bit on_irq, input int n);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(negedge pclk);
            if ((on_irq ? irq : pready) === 1'h1)
            begin
                @(posedge pclk);
                break;
            end
        end
        if (i == n) finish_test(1'h1);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk) penable <= 1'h1;
        wait_for(1'h0, 20);
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        q.push_back(x);
        apb(1'h0, a, 32'h0);
    endtask
    always @(posedge pclk)
        if (psel && penable && pready === 1'h1 && !pwrite)
        begin
            e = q.pop_front();
            num_checks++;
            if (prdata !== e) $display("[ERR] %0t got %h exp %h", $time, prdata, e);
            fails += int'(prdata !== e);
        end
    task finish_test(input bit hung);
        fails += int'(hung);
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
        m = $random(seed) | 32'h8;
        apb(1'h1, RSW_MATCH_OFS, m);
        apb(1'h1, RSW_COUNT_OFS, m - 3);
        rd(RSW_MATCH_OFS, m);
        apb(1'h1, RSW_MASK_OFS, 32'h1);
        apb(1'h1, RSW_CTRL_OFS, 32'h2);
        apb(1'h1, RSW_COUNT_OFS, 32'h0);
        wait_for(1'h1, 300);
        rd(RSW_COUNT_OFS, m);
        $display("test 1 done");
        apb(1'h1, RSW_MASK_OFS, 32'h0);
        apb(1'h1, RSW_CTRL_OFS, 32'h0);
        apb(1'h1, RSW_WAKE_OFS, 32'h3);
        rd(RSW_CTRL_OFS, 32'h4);
        repeat (40) @(posedge pclk);
        rd(RSW_WAKE_OFS, 32'h3);
        rd(RSW_WAKE_OFS, 32'h3);
        apb(1'h1, RSW_MASK_OFS, 32'h2);
        apb(1'h1, RSW_CTRL_OFS, 32'h26);
        wait_for(1'h1, 300);
        rd(RSW_WAKE_OFS, 32'h0);
        rd(RSW_STAT_OFS, 32'h3);
        apb(1'h1, RSW_STAT_OFS, 32'h3);
        rd(RSW_STAT_OFS, 32'h1);
        $display("test 2 done");
        apb(1'h1, RSW_CTRL_OFS, 32'h2);
        apb(1'h1, RSW_CTRL_OFS, 32'ha);
        apb(1'h1, RSW_CTRL_OFS, 32'h2);
        rd(RSW_SUBS_OFS, 32'h1);
        apb(1'h1, RSW_CTRL_OFS, 32'h1);
        for (int a = 0; a < 32; a += 4) rd(8'(a), 32'(a == 0));
        $display("test 3 done");
        finish_test(1'h0);
    end
endmodule
